// [verilog/cffmb_regs.svh]
// Register offsets, field positions, reset values and scale figures
// for the charger flag and mask bank.
// Assumes inclusion by bare name from the main module.
`ifndef CFFMB_REGS_SVH
`define CFFMB_REGS_SVH

// Register offsets on the register port
`define CFFMB_ADDR_EVENT_FLAGS_TIMERS 8'h06
`define CFFMB_ADDR_EVENT_MASK_CHARGE 8'h07
`define CFFMB_ADDR_EVENT_MASK_FAULTS_TEMP 8'h08
`define CFFMB_ADDR_EVENT_MASK_THERMISTOR_OPEN 8'h09
`define CFFMB_ADDR_EVENT_MASK_TIMERS 8'h0a
`define CFFMB_ADDR_VBAT 8'h12

// Reset values
`define CFFMB_RST_EVENT_MASK_CHARGE 8'h00
`define CFFMB_RST_EVENT_MASK_FAULTS_TEMP 8'h00
`define CFFMB_RST_EVENT_MASK_THERMISTOR_OPEN 8'h71
`define CFFMB_RST_EVENT_MASK_TIMERS 8'h00
`define CFFMB_RST_VBAT 8'h3c

// Timer and fault flag positions, shared by the timer mask register
`define CFFMB_BIT_WATCHDOG 6
`define CFFMB_BIT_SAFETY 5
`define CFFMB_BIT_LDO_OCP 4
`define CFFMB_BIT_WAKE1 2
`define CFFMB_BIT_WAKE2 1
`define CFFMB_BIT_RST_WARN 0

// Charge event mask positions
`define CFFMB_BIT_CV 6
`define CFFMB_BIT_DONE 5
`define CFFMB_BIT_IINLIM 4
`define CFFMB_BIT_DPPM 3
`define CFFMB_BIT_VINDPM 2
`define CFFMB_BIT_THERMREG 1
`define CFFMB_BIT_PGOOD 0

// Fault and temperature mask positions
`define CFFMB_BIT_VIN_OVP 7
`define CFFMB_BIT_BAT_OCP 5
`define CFFMB_BIT_BAT_UVLO 4
`define CFFMB_BIT_TS_COLD 3
`define CFFMB_BIT_TS_COOL 2
`define CFFMB_BIT_TS_WARM 1
`define CFFMB_BIT_TS_HOT 0

// Thermistor open mask position and the fixed upper nibble of its register
`define CFFMB_BIT_TS_OPEN 0
`define CFFMB_EVENT_MASK_THERMISTOR_OPEN_FIXED 4'h7

// Bits that carry an event source in the timer flag, charge mask and fault mask registers
`define CFFMB_USED_EVENT_FLAGS_TIMERS 8'h77
`define CFFMB_USED_EVENT_MASK_CHARGE 8'h7f
`define CFFMB_USED_EVENT_MASK_FAULTS_TEMP 8'hbf

// Battery regulation scale in millivolts
`define CFFMB_VBAT_BASE_MV 3600
`define CFFMB_VBAT_STEP_MV 10
`define CFFMB_VBAT_MAX_MV 4600

`endif

// [verilog/cffmb_pkg.sv]
// Types shared by the charger flag and mask bank.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package cffmb_pkg;
    typedef logic [7:0] cffmb_byte_t;
    typedef logic [6:0] cffmb_vcode_t;

    // Register selected by an address
    typedef enum logic [2:0] {
        CFFMB_SEL_NONE  = 3'b000,
        CFFMB_SEL_EVENT_FLAGS_TIMERS = 3'b001,
        CFFMB_SEL_EVENT_MASK_CHARGE = 3'b010,
        CFFMB_SEL_EVENT_MASK_FAULTS_TEMP = 3'b011,
        CFFMB_SEL_EVENT_MASK_THERMISTOR_OPEN = 3'b100,
        CFFMB_SEL_EVENT_MASK_TIMERS = 3'b101,
        CFFMB_SEL_VBAT  = 3'b110
    } cffmb_sel_t;
endpackage

`default_nettype wire

// [verilog/cffmb_event_sync.sv]
// Three-stage synchroniser with rising-edge pulse for event pins.
// Assumes asynchronous level inputs; one pulse per settled rise.
`default_nettype none

module cffmb_event_sync #(
    parameter int WIDTH = 6
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Event levels and their rise pulses
    input wire logic [WIDTH-1:0] level_in,
    output logic [WIDTH-1:0] rise_pulse
);

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic s1;
            logic s2;
            logic s3;
            logic settled;

            // Stages; a change counts once stages two and three agree
            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    s1 <= 1'b0;
                    s2 <= 1'b0;
                    s3 <= 1'b0;
                end else begin
                    s1 <= level_in[i];
                    s2 <= s1;
                    s3 <= s2;
                end
            end

            // Settled level and a one-cycle pulse on its rise
            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    settled <= 1'b0;
                    rise_pulse[i] <= 1'b0;
                end else begin
                    if (s2 == s3) begin
                        settled <= s2;
                    end
                    rise_pulse[i] <= (s2 == s3) && s2 && !settled;
                end
            end
        end
    endgenerate

endmodule

`default_nettype wire

// [verilog/cffmb_bank.sv]
// Flag and mask bank of a single-cell charger: timer fault flags that
// clear on read, four interrupt mask registers, battery regulation code.
// Assumes a register engine on the same clock that issues one-cycle
// read and write strobes; event pins are asynchronous levels.
`default_nettype none

`include "cffmb_regs.svh"

// Function
// - Watchdog expiry sets timer flag bit six
// - Safety timer expiry sets flag bit five
// - Regulator overcurrent sets flag bit four
// - First wake timer sets flag bit two
// - Second wake timer sets flag bit one
// - Reset warning timer sets flag bit zero
// - Charge mask bit six gates constant-voltage event
// - Charge mask bit five gates termination event
// - Bits four to two gate input limits
// - Bits one, zero gate thermal, power-good events
// - Fault mask gates overvoltage, battery current, undervoltage
// - Fault mask low bits gate temperature regions
// - Thermistor open masked after reset, reads 0x71
// - Timer mask gates watchdog and safety timer
// - Timer mask bit four gates regulator overcurrent
// - Timer mask low bits gate button timers
// - Other mask registers reset to zero
// - Regulation code is 3.6 V plus 10 mV steps
// - Codes above 4.6 V clamp to 4.6 V
// - Regulation code resets to 4.2 V
module cffmb_bank (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Register port
    input wire cffmb_pkg::cffmb_byte_t reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire cffmb_pkg::cffmb_byte_t reg_wdata,
    output cffmb_pkg::cffmb_byte_t reg_rdata,
    output logic reg_rvalid,
    // Asynchronous timer and fault event pins
    input wire logic watchdog_expired,
    input wire logic safety_timer_expired,
    input wire logic regulator_overcurrent,
    input wire logic button_wake_first_expired,
    input wire logic button_wake_second_expired,
    input wire logic button_reset_warning_expired,
    // Flag set pulses of the other flag registers, same clock
    input wire logic [6:0] charge_flag_set,
    input wire cffmb_pkg::cffmb_byte_t fault_temp_flag_set,
    input wire logic thermistor_open_set,
    // Interrupt and regulation setting
    output logic irq,
    output cffmb_pkg::cffmb_vcode_t battery_regulation_voltage_level
);
    import cffmb_pkg::*;

    // Highest legal regulation code, from the millivolt scale
    localparam int VCODE_MAX_INT =
        (`CFFMB_VBAT_MAX_MV - `CFFMB_VBAT_BASE_MV) / `CFFMB_VBAT_STEP_MV;
    localparam cffmb_vcode_t VCODE_MAX = cffmb_vcode_t'(VCODE_MAX_INT);

    // Address decode, shared by the write and read paths
    function automatic cffmb_sel_t decode(input cffmb_byte_t addr);
        cffmb_sel_t sel;
        if (addr == `CFFMB_ADDR_EVENT_FLAGS_TIMERS) begin
            sel = CFFMB_SEL_EVENT_FLAGS_TIMERS;
        end else if (addr == `CFFMB_ADDR_EVENT_MASK_CHARGE) begin
            sel = CFFMB_SEL_EVENT_MASK_CHARGE;
        end else if (addr == `CFFMB_ADDR_EVENT_MASK_FAULTS_TEMP) begin
            sel = CFFMB_SEL_EVENT_MASK_FAULTS_TEMP;
        end else if (addr == `CFFMB_ADDR_EVENT_MASK_THERMISTOR_OPEN) begin
            sel = CFFMB_SEL_EVENT_MASK_THERMISTOR_OPEN;
        end else if (addr == `CFFMB_ADDR_EVENT_MASK_TIMERS) begin
            sel = CFFMB_SEL_EVENT_MASK_TIMERS;
        end else if (addr == `CFFMB_ADDR_VBAT) begin
            sel = CFFMB_SEL_VBAT;
        end else begin
            sel = CFFMB_SEL_NONE;
        end
        return sel;
    endfunction

    cffmb_sel_t sel;
    logic [5:0] pin_levels;
    logic [5:0] pin_rise;
    cffmb_byte_t timer_set;
    cffmb_byte_t flags;
    cffmb_byte_t mask_charge;
    cffmb_byte_t mask_fault;
    logic [3:0] mask_open_low;
    cffmb_byte_t mask_timer;
    logic vbat_reserved;
    cffmb_byte_t mask_open_read;
    logic flag_read;
    logic next_irq;
    cffmb_byte_t next_rdata;

    assign sel = decode(reg_addr);
    assign flag_read = reg_rd && (sel == CFFMB_SEL_EVENT_FLAGS_TIMERS);
    assign mask_open_read = {`CFFMB_EVENT_MASK_THERMISTOR_OPEN_FIXED, mask_open_low};

    // Event pins gathered in flag order
    assign pin_levels = {watchdog_expired, safety_timer_expired,
                         regulator_overcurrent, button_wake_first_expired,
                         button_wake_second_expired,
                         button_reset_warning_expired};

    cffmb_event_sync #(
        .WIDTH(6)
    ) u_sync (
        .clk(clk),
        .arst_n(arst_n),
        .level_in(pin_levels),
        .rise_pulse(pin_rise)
    );

    // Rise pulses placed at their flag positions
    always_comb begin
        timer_set = 8'h00;
        timer_set[`CFFMB_BIT_WATCHDOG] = pin_rise[5];
        timer_set[`CFFMB_BIT_SAFETY] = pin_rise[4];
        timer_set[`CFFMB_BIT_LDO_OCP] = pin_rise[3];
        timer_set[`CFFMB_BIT_WAKE1] = pin_rise[2];
        timer_set[`CFFMB_BIT_WAKE2] = pin_rise[1];
        timer_set[`CFFMB_BIT_RST_WARN] = pin_rise[0];
    end

    // Sticky timer flags; a new event beats the clear of the same read
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            flags <= 8'h00;
        end else if (flag_read) begin
            flags <= timer_set;
        end else begin
            flags <= flags | timer_set;
        end
    end

    // Charge and fault mask registers, plain read-write
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mask_charge <= `CFFMB_RST_EVENT_MASK_CHARGE;
            mask_fault <= `CFFMB_RST_EVENT_MASK_FAULTS_TEMP;
        end else if (reg_wr && sel == CFFMB_SEL_EVENT_MASK_CHARGE) begin
            mask_charge <= reg_wdata;
        end else if (reg_wr && sel == CFFMB_SEL_EVENT_MASK_FAULTS_TEMP) begin
            mask_fault <= reg_wdata;
        end
    end

    // Thermistor mask register; upper nibble is fixed
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mask_open_low <= 4'(`CFFMB_RST_EVENT_MASK_THERMISTOR_OPEN & 8'h0f);
        end else if (reg_wr && sel == CFFMB_SEL_EVENT_MASK_THERMISTOR_OPEN) begin
            mask_open_low <= reg_wdata[3:0];
        end
    end

    // Timer mask register, reserved bits kept as written
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mask_timer <= `CFFMB_RST_EVENT_MASK_TIMERS;
        end else if (reg_wr && sel == CFFMB_SEL_EVENT_MASK_TIMERS) begin
            mask_timer <= reg_wdata;
        end
    end

    // Battery regulation code with upper clamp
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            vbat_reserved <= 1'(`CFFMB_RST_VBAT >> 7);
            battery_regulation_voltage_level <= 7'(`CFFMB_RST_VBAT & 8'h7f);
        end else if (reg_wr && sel == CFFMB_SEL_VBAT) begin
            vbat_reserved <= reg_wdata[7];
            // code in bits six to zero
            if (reg_wdata[6:0] > VCODE_MAX) begin
                battery_regulation_voltage_level <= VCODE_MAX;
            end else begin
                battery_regulation_voltage_level <= reg_wdata[6:0];
            end
        end
    end

    // Interrupt request from any newly set flag whose mask is clear
    always_comb begin
        next_irq = |(charge_flag_set & ~mask_charge[6:0]
                     & `CFFMB_USED_EVENT_MASK_CHARGE);
        next_irq = next_irq | (|(fault_temp_flag_set & ~mask_fault
                                 & `CFFMB_USED_EVENT_MASK_FAULTS_TEMP));
        next_irq = next_irq
                   | (thermistor_open_set
                      & ~mask_open_low[`CFFMB_BIT_TS_OPEN]);
        next_irq = next_irq | (|(timer_set & ~mask_timer
                                 & `CFFMB_USED_EVENT_FLAGS_TIMERS));
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= next_irq;
        end
    end

    // Read data mux; unmapped offsets read zero
    always_comb begin
        case (sel)
            CFFMB_SEL_EVENT_FLAGS_TIMERS: next_rdata = flags & `CFFMB_USED_EVENT_FLAGS_TIMERS;
            CFFMB_SEL_EVENT_MASK_CHARGE: next_rdata = mask_charge;
            CFFMB_SEL_EVENT_MASK_FAULTS_TEMP: next_rdata = mask_fault;
            CFFMB_SEL_EVENT_MASK_THERMISTOR_OPEN: next_rdata = mask_open_read;
            CFFMB_SEL_EVENT_MASK_TIMERS: next_rdata = mask_timer;
            CFFMB_SEL_VBAT: begin
                next_rdata = {vbat_reserved,
                              battery_regulation_voltage_level};
            end
            default: next_rdata = 8'h00;
        endcase
    end

    // Read answer one cycle after the strobe
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                reg_rdata <= next_rdata;
            end
        end
    end

    // Assertions

    sequence s_wd_rise;
        !watchdog_expired [*3] ##1 watchdog_expired [*4];
    endsequence

    sequence s_flag_read_quiet;
        flag_read && (timer_set == 8'h00);
    endsequence

    sequence s_vbat_write;
        reg_wr && (sel == CFFMB_SEL_VBAT);
    endsequence

    // watchdog flag after settled rise, no read in the way
    a_wd_flag_set: assert property (
        @(posedge clk) disable iff (!arst_n)
        s_wd_rise ##0 !flag_read |-> ##2 flags[`CFFMB_BIT_WATCHDOG])
        else $error("watchdog flag not set after pin rise");

    // safety timer pulse sets its flag next cycle
    a_safety_flag: assert property (
        @(posedge clk) disable iff (!arst_n)
        timer_set[`CFFMB_BIT_SAFETY]
        |=> flags[`CFFMB_BIT_SAFETY])
        else $error("safety timer flag missed");

    // overcurrent flag stays clear without its event
    a_ldo_flag_cause: assert property (
        @(posedge clk) disable iff (!arst_n)
        $rose(flags[`CFFMB_BIT_LDO_OCP])
        |-> $past(timer_set[`CFFMB_BIT_LDO_OCP]))
        else $error("overcurrent flag set without event");

    // read returns the flags, then they clear
    a_read_clear: assert property (
        @(posedge clk) disable iff (!arst_n)
        s_flag_read_quiet
        |=> reg_rvalid && (flags == 8'h00)
            && (reg_rdata == ($past(flags) & `CFFMB_USED_EVENT_FLAGS_TIMERS)))
        else $error("flag read did not return and clear");

    // an event during the clearing read survives
    a_set_wins: assert property (
        @(posedge clk) disable iff (!arst_n)
        flag_read && timer_set[`CFFMB_BIT_WAKE1]
        |=> flags[`CFFMB_BIT_WAKE1])
        else $error("event lost in clearing read");

    // unmasked constant-voltage event raises the interrupt
    a_cv_irq: assert property (
        @(posedge clk) disable iff (!arst_n)
        charge_flag_set[`CFFMB_BIT_CV] && !mask_charge[`CFFMB_BIT_CV]
        |=> irq)
        else $error("unmasked charge event gave no interrupt");

    // interrupt only from an unmasked source
    a_irq_cause: assert property (
        @(posedge clk) disable iff (!arst_n)
        !next_irq |=> !irq)
        else $error("interrupt without unmasked source");

    // masked watchdog alone gives no interrupt
    a_wd_masked: assert property (
        @(posedge clk) disable iff (!arst_n)
        timer_set == 8'h40 && mask_timer[`CFFMB_BIT_WATCHDOG]
        && charge_flag_set == 7'h00 && fault_temp_flag_set == 8'h00
        && !thermistor_open_set |=> !irq)
        else $error("masked watchdog raised interrupt");

    // writes above the ceiling read back as the ceiling
    a_vbat_clamp: assert property (
        @(posedge clk) disable iff (!arst_n)
        s_vbat_write ##0 (reg_wdata[6:0] > 7'h64)
        |=> battery_regulation_voltage_level == 7'h64)
        else $error("regulation code not clamped");

    // in-range codes are kept as written
    a_vbat_keep: assert property (
        @(posedge clk) disable iff (!arst_n)
        s_vbat_write ##0 (reg_wdata[6:0] <= 7'h64)
        |=> battery_regulation_voltage_level == $past(reg_wdata[6:0]))
        else $error("regulation code altered");

    // thermistor mask register reads its fixed upper nibble
    a_event_mask_thermistor_open_fixed: assert property (
        @(posedge clk) disable iff (!arst_n)
        reg_rd && sel == CFFMB_SEL_EVENT_MASK_THERMISTOR_OPEN |=> reg_rdata[7:4] == 4'h7)
        else $error("thermistor mask upper bits wrong");

endmodule

`default_nettype wire

// [sim/cffmb_host_model.sv]
// Host processor model on the register port: byte writes and reads.
// Assumes the bank's clock; reads note their expected answer in exp_q.
`default_nettype none

module cffmb_host_model (
    // Clock
    input wire logic clk,
    // Register port towards the bank
    output var cffmb_pkg::cffmb_byte_t reg_addr,
    output var logic reg_wr,
    output var logic reg_rd,
    output var cffmb_pkg::cffmb_byte_t reg_wdata
);
    timeunit 1ns;
    timeprecision 1ns;
    import cffmb_pkg::*;

    // Expected read answers, oldest first
    cffmb_byte_t exp_q[$];

    // Idle port at time zero
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h00;
    end

    // One-cycle write strobe; released data is inverted, never held
    task automatic wr(input cffmb_byte_t a, input cffmb_byte_t d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
    endtask

    // host reads any register
    // One-cycle read strobe; the answer is noted for the bench
    task automatic rd(input cffmb_byte_t a, input cffmb_byte_t e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask
endmodule

`default_nettype wire

// [sim/cffmb_bank_tb.sv]
// Self-checking bench of the charger flag and mask bank.
// Assumes the host model drives the register port; pins come from here.
`default_nettype none

module cffmb_bank_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import cffmb_pkg::*;

    localparam int base_mv = 3600;
    localparam int step_mv = 10;
    localparam int max_mv = 4600;
    localparam int max_cycles = 20000;

    logic clk;
    logic arst_n;
    logic reg_wr, reg_rd, reg_rvalid, ts_open_set, irq;
    cffmb_byte_t reg_addr, reg_wdata, reg_rdata, fault_set;
    logic [6:0] charge_set;
    logic [5:0] ev;
    cffmb_vcode_t vlevel;
    int failures = 0;
    int num_checks = 0;
    int cycles = 0;
    int irq_seen = 0;
    int seed = 32'h5317dd66;
    int flag_bit[6] = '{6, 5, 4, 2, 1, 0};
    cffmb_byte_t rw_addr[3] = '{8'h07, 8'h08, 8'h0a};
    cffmb_byte_t vcodes[6] = '{8'h00, 8'h3c, 8'h64, 8'h65, 8'h7f, 8'hff};

    cffmb_host_model host (
        .clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata)
    );

    cffmb_bank dut (
        .clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .watchdog_expired(ev[0]), .safety_timer_expired(ev[1]),
        .regulator_overcurrent(ev[2]), .button_wake_first_expired(ev[3]),
        .button_wake_second_expired(ev[4]),
        .button_reset_warning_expired(ev[5]),
        .charge_flag_set(charge_set), .fault_temp_flag_set(fault_set),
        .thermistor_open_set(ts_open_set), .irq(irq),
        .battery_regulation_voltage_level(vlevel)
    );

    // 10 MHz clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic check(input string name, input cffmb_byte_t seen,
                         input cffmb_byte_t exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Hang guard and irq pulse counter
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (irq === 1'b1) begin
            irq_seen <= irq_seen + 1;
        end
        if (cycles == max_cycles) begin
            failures++;
            print_verdict();
        end
    end

    // Read answers against the oldest note
    always @(posedge clk) begin
        if (reg_rvalid === 1'b1) begin
            if (host.exp_q.size() == 0) begin
                failures++;
                $display("unexpected read answer: expected none, seen %h",
                         reg_rdata);
            end else begin
                check("read data", reg_rdata,
                      host.exp_q.pop_front());
            end
        end
    end

    task automatic do_reset();
        arst_n <= 1'b0;
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
    endtask

    task automatic reset_values();
        check("level", {1'b0, vlevel}, 8'h3c);
        host.rd(8'h06, 8'h00);
        host.rd(8'h07, 8'h00);
        host.rd(8'h08, 8'h00);
        host.rd(8'h09, 8'h71);
        host.rd(8'h0a, 8'h00);
        host.rd(8'h12, 8'h3c);
    endtask

    // Level rise on one event pin, held, then settled low
    task automatic pin_event(input int i, input int n);
        int base;
        base = irq_seen;
        @(posedge clk);
        ev[i] <= 1'b1;
        repeat (6) @(posedge clk);
        ev[i] <= 1'b0;
        repeat (8) @(posedge clk);
        check("irq pulses", 8'(irq_seen - base), 8'(n));
    endtask

    // One-cycle set pulse: 0 charge, 1 fault and temperature, 2 open
    task automatic set_pulse(input int sel, input int i, input int n);
        int base;
        base = irq_seen;
        @(posedge clk);
        if (sel == 0) charge_set[i] <= 1'b1;
        else if (sel == 1) fault_set[i] <= 1'b1;
        else ts_open_set <= 1'b1;
        @(posedge clk);
        charge_set <= 7'h00;
        fault_set <= 8'h00;
        ts_open_set <= 1'b0;
        repeat (3) @(posedge clk);
        check("irq pulses", 8'(irq_seen - base), 8'(n));
    endtask

    initial begin
        int k;
        cffmb_byte_t d, bitv;
        cffmb_vcode_t c;
        arst_n = 1'b0;
        ev = 6'h00;
        charge_set = 7'h00;
        fault_set = 8'h00;
        ts_open_set = 1'b0;
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        reset_values();
        // Unmapped offset and read-only flag register
        host.wr(8'h20, 8'h5a);
        host.rd(8'h20, 8'h00);
        host.wr(8'h06, 8'hff);
        host.rd(8'h06, 8'h00);
        for (k = 0; k < 3; k++) begin
            d = $random(seed);
            host.wr(rw_addr[k], d);
            host.rd(rw_addr[k], d);
            host.wr(rw_addr[k], 8'h00);
        end
        d = $random(seed);
        host.wr(8'h09, d);
        host.rd(8'h09, {4'h7, d[3:0]});
        for (k = 0; k < 6; k++) begin
            bitv = 8'h01 << flag_bit[k];
            pin_event(k, 1);
            host.rd(8'h06, bitv);
            host.rd(8'h06, 8'h00);
            host.wr(8'h0a, bitv);
            pin_event(k, 0);
            host.rd(8'h06, bitv);
            host.wr(8'h0a, 8'h00);
        end
        for (k = 0; k < 7; k++) begin
            bitv = 8'h01 << k;
            host.wr(8'h07, ~bitv);
            set_pulse(0, k, 1);
            host.wr(8'h07, bitv);
            set_pulse(0, k, 0);
        end
        // fault and temperature masks, bit six unused
        for (k = 0; k < 8; k++) begin
            bitv = 8'h01 << k;
            host.wr(8'h08, ~bitv);
            set_pulse(1, k, (k == 6) ? 0 : 1);
            host.wr(8'h08, bitv);
            set_pulse(1, k, 0);
        end
        for (k = 0; k < 7; k++) begin
            d = (k < 6) ? vcodes[k] : 8'($random(seed));
            c = d[6:0];
            if (base_mv + step_mv * int'(c) > max_mv) begin
                c = 7'((max_mv - base_mv) / step_mv);
            end
            host.wr(8'h12, d);
            // Level updates on the strobe edge; look once it has settled
            @(negedge clk);
            check("level", {1'b0, vlevel}, {1'b0, c});
            host.rd(8'h12, {d[7], c});
        end
        // Reset in mid-run restores every register
        repeat (4) @(posedge clk);
        do_reset();
        reset_values();
        set_pulse(2, 0, 0);
        host.wr(8'h09, 8'h00);
        set_pulse(2, 0, 1);
        repeat (4) @(posedge clk);
        // Every noted read must have been answered
        check("pending reads", 8'(host.exp_q.size()), 8'h00);
        print_verdict();
    end
endmodule

`default_nettype wire
